/* File: hdl/ccr_top.sv */
`include "ccr_params.svh"

module ccr_top (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic divider_input_clock,
	input wire logic pll_rate_tick,
	output logic active_page,
	output logic pll_enable,
	output logic [3:0] pll_q_code,
	output logic [3:0] adc_rate_code,
	output logic [3:0] dac_rate_code,
	output logic soft_reset_busy,
	output logic reference_sample_rate,
	output logic adc_sample_tick,
	output logic dac_sample_tick
);

	ccr_pkg::ccr_top_st_t st_ff;
	ccr_pkg::ccr_top_st_t nxt_st;
	logic [4:0] q_val;
	logic [11:0] ref_terminal;
	logic div_edge;
	logic soft_clr;

	// ****************************************
	// Register access and soft reset
	// ****************************************
	always_comb
	begin
		nxt_st = st_ff;
		soft_clr = 1'b0;
		nxt_st.div_sync = {st_ff.div_sync[0], divider_input_clock};
		nxt_st.div_prev = st_ff.div_sync[1];
		nxt_st.ref_tick = 1'b0;
		case (st_ff.state)
			ccr_pkg::CCR_ST_IDLE:
			begin
				if (reg_wr)
				begin
					if (reg_addr == `CCR_ADDR_PAGE)
					begin
						nxt_st.page = reg_wdata[`CCR_PAGE_BIT]; // RULE2
					end
					else if (st_ff.page == 1'b0 && reg_addr == `CCR_ADDR_RESET)
					begin
						if (reg_wdata[`CCR_SWRST_BIT])
						begin
							nxt_st.state = ccr_pkg::CCR_ST_CLEAR; // RULE5
							nxt_st.busy = 1'b1;
						end
					end
					else if (st_ff.page == 1'b0 && reg_addr == `CCR_ADDR_RATE)
					begin
						nxt_st.rate = reg_wdata; // RULE7 RULE8
					end
					else if (st_ff.page == 1'b0 && reg_addr == `CCR_ADDR_PLL)
					begin
						nxt_st.pll = reg_wdata; // RULE11
					end
				end
				if (reg_rd)
				begin
					if (reg_addr == `CCR_ADDR_PAGE)
					begin
						// Upper bits always read zero
						nxt_st.rdata = {7'h00, st_ff.page}; // RULE3 RULE4
					end
					else if (st_ff.page == 1'b0 && reg_addr == `CCR_ADDR_RATE)
					begin
						nxt_st.rdata = st_ff.rate; // RULE1
					end
					else if (st_ff.page == 1'b0 && reg_addr == `CCR_ADDR_PLL)
					begin
						nxt_st.rdata = st_ff.pll;
					end
					else
					begin
						// Write-only reset register and unmapped numbers read zero
						nxt_st.rdata = `CCR_RDATA_ZERO;
					end
				end
			end
			ccr_pkg::CCR_ST_CLEAR:
			begin
				// Defaults land on the same edge that drops busy
				soft_clr = 1'b1;
				nxt_st.page = `CCR_RST_PAGE; // RULE13
				nxt_st.rate = `CCR_RST_RATE;
				nxt_st.pll = `CCR_RST_PLL;
				nxt_st.rdata = `CCR_RDATA_ZERO;
				nxt_st.div_cnt = `CCR_CNT_ZERO;
				nxt_st.busy = 1'b0; // RULE5
				nxt_st.state = ccr_pkg::CCR_ST_IDLE;
			end
			default:
			begin
				nxt_st.state = ccr_pkg::CCR_ST_IDLE;
			end
		endcase

		// ****************************************
		// Reference sample rate source
		// ****************************************
		if (st_ff.state == ccr_pkg::CCR_ST_IDLE)
		begin
			if (st_ff.pll[`CCR_PLL_EN_BIT])
			begin
				nxt_st.div_cnt = `CCR_CNT_ZERO;
				nxt_st.ref_tick = pll_rate_tick; // RULE11
			end
			else if (div_edge)
			begin
				if (st_ff.div_cnt >= ref_terminal)
				begin
					nxt_st.div_cnt = `CCR_CNT_ZERO;
					nxt_st.ref_tick = 1'b1; // RULE12
				end
				else
				begin
					nxt_st.div_cnt = st_ff.div_cnt + `CCR_CNT_ONE;
				end
			end
		end
	end

	// Q code decode and count limit of 128*Q input cycles
	always_comb
	begin
		if (st_ff.pll[`CCR_Q_HI:`CCR_Q_LO] == `CCR_Q_CODE_16)
		begin
			q_val = `CCR_Q_16;
		end
		else if (st_ff.pll[`CCR_Q_HI:`CCR_Q_LO] == `CCR_Q_CODE_17)
		begin
			q_val = `CCR_Q_17;
		end
		else
		begin
			q_val = {1'b0, st_ff.pll[`CCR_Q_HI:`CCR_Q_LO]};
		end
		ref_terminal = 12'(q_val * `CCR_REF_DIV) - `CCR_CNT_ONE; // RULE12
	end

	assign div_edge = st_ff.div_sync[1] & ~st_ff.div_prev;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_ff.state <= ccr_pkg::CCR_ST_IDLE;
			st_ff.page <= `CCR_RST_PAGE;
			st_ff.rate <= `CCR_RST_RATE;
			st_ff.pll <= `CCR_RST_PLL;
			st_ff.rdata <= `CCR_RDATA_ZERO;
			st_ff.busy <= 1'b0;
			st_ff.div_sync <= 2'h0;
			st_ff.div_prev <= 1'b0;
			st_ff.div_cnt <= `CCR_CNT_ZERO;
			st_ff.ref_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Converter rate dividers
	// ****************************************
	ccr_rate_div u_adc_div (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.soft_clr(soft_clr),
		.ref_tick(st_ff.ref_tick),
		.rate_code(st_ff.rate[`CCR_ADC_HI:`CCR_ADC_LO]),
		.conv_tick(adc_sample_tick)
	);

	ccr_rate_div u_dac_div (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.soft_clr(soft_clr),
		.ref_tick(st_ff.ref_tick),
		.rate_code(st_ff.rate[`CCR_DAC_HI:`CCR_DAC_LO]),
		.conv_tick(dac_sample_tick)
	);

	assign reg_rdata = st_ff.rdata;
	assign active_page = st_ff.page;
	assign pll_enable = st_ff.pll[`CCR_PLL_EN_BIT];
	assign pll_q_code = st_ff.pll[`CCR_Q_HI:`CCR_Q_LO];
	assign adc_rate_code = st_ff.rate[`CCR_ADC_HI:`CCR_ADC_LO];
	assign dac_rate_code = st_ff.rate[`CCR_DAC_HI:`CCR_DAC_LO];
	assign soft_reset_busy = st_ff.busy;
	assign reference_sample_rate = st_ff.ref_tick;

endmodule

/* File: hdl/ccr_params.svh */
// Summary of operation
// RULE1 - All control registers are eight bits wide
// RULE2 - Page bit selects page zero or one
// RULE3 - Host writes zeros; reserved page bits read zero
// RULE4 - Host reads page bit back after writing
// RULE5 - Reset bit one starts self-clearing reset
// RULE6 - Host leaves reset register low bits unwritten
// RULE7 - ADC field divides reference rate, half steps
// RULE8 - DAC field divides reference rate, same codes
// RULE9 - Host never writes reserved ADC rate codes
// RULE10 - Host sets ADC field equal to DAC
// RULE11 - PLL enable bit, default disabled
// RULE12 - PLL off: reference rate is input/(128*Q)
// RULE13 - Soft reset restores defaults before bit clears; the code restores them on the same edge that clears busy
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ****************************************
// Register numbers
// ****************************************
`define CCR_ADDR_PAGE 7'h00
`define CCR_ADDR_RESET 7'h01
`define CCR_ADDR_RATE 7'h02
`define CCR_ADDR_PLL 7'h03

// ****************************************
// Reset values
// ****************************************
`define CCR_RST_PAGE 1'h0
`define CCR_RST_RATE 8'h00
`define CCR_RST_PLL 8'h10
`define CCR_RDATA_ZERO 8'h00

// ****************************************
// Field positions
// ****************************************
`define CCR_PAGE_BIT 0
`define CCR_SWRST_BIT 7
`define CCR_ADC_HI 7
`define CCR_ADC_LO 4
`define CCR_DAC_HI 3
`define CCR_DAC_LO 0
`define CCR_PLL_EN_BIT 7
`define CCR_Q_HI 6
`define CCR_Q_LO 3

// ****************************************
// Divider constants
// ****************************************
`define CCR_REF_DIV 12'h080
`define CCR_Q_CODE_16 4'h0
`define CCR_Q_CODE_17 4'h1
`define CCR_Q_16 5'h10
`define CCR_Q_17 5'h11
`define CCR_RATE_MAX_CODE 4'ha
`define CCR_HALF_STEP 4'h2
`define CCR_CNT_ZERO 12'h000
`define CCR_CNT_ONE 12'h001

`endif

/* File: hdl/ccr_pkg.sv */
package ccr_pkg;

	typedef enum logic [0:0] {
		CCR_ST_IDLE,
		CCR_ST_CLEAR
	} ccr_state_t;

	typedef struct packed {
		ccr_state_t state;
		logic page;
		logic [7:0] rate;
		logic [7:0] pll;
		logic [7:0] rdata;
		logic busy;
		logic [1:0] div_sync;
		logic div_prev;
		logic [11:0] div_cnt;
		logic ref_tick;
	} ccr_top_st_t;

	typedef struct packed {
		logic [3:0] acc;
		logic tick;
	} ccr_div_st_t;

endpackage

/* File: hdl/ccr_rate_div.sv */
`include "ccr_params.svh"

module ccr_rate_div (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic soft_clr,
	input wire logic ref_tick,
	input wire logic [3:0] rate_code,
	output logic conv_tick
);

	ccr_pkg::ccr_div_st_t st_ff;
	ccr_pkg::ccr_div_st_t nxt_st;
	logic [3:0] code_lim;
	logic [3:0] div_halves;
	logic [3:0] sum;

	// ****************************************
	// Fractional divide in half steps
	// ****************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		code_lim = (rate_code > `CCR_RATE_MAX_CODE) ? `CCR_RATE_MAX_CODE : rate_code;
		div_halves = code_lim + `CCR_HALF_STEP; // RULE7
		sum = st_ff.acc + `CCR_HALF_STEP;
		if (soft_clr)
		begin
			nxt_st.acc = 4'h0;
		end
		else if (ref_tick)
		begin
			if (sum >= div_halves)
			begin
				nxt_st.acc = sum - div_halves; // RULE8
				nxt_st.tick = 1'b1;
			end
			else
			begin
				nxt_st.acc = sum;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_ff <= '0;
		end
		else if (clk_en)
		begin
			st_ff <= nxt_st;
		end
	end

	assign conv_tick = st_ff.tick;

endmodule

/* File: test/ccr_chk.sv */
module ccr_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic pll_rate_tick,
	input wire logic active_page,
	input wire logic pll_enable,
	input wire logic [3:0] pll_q_code,
	input wire logic [3:0] adc_rate_code,
	input wire logic [3:0] dac_rate_code,
	input wire logic soft_reset_busy,
	input wire logic reference_sample_rate
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic w;
	assign w = clk_en && reg_wr && !soft_reset_busy && !active_page;
	property p_pg;
		clk_en && reg_wr && !soft_reset_busy && reg_addr == 7'h00
			|=> active_page == $past(reg_wdata[0]);
	endproperty
	a_pg: assert property (p_pg) else $error("page");
	property p_rst;
		w && reg_addr == 7'h01 && reg_wdata[7] |=> soft_reset_busy ##1 !soft_reset_busy
			&& !active_page && adc_rate_code == 4'h0 && !pll_enable && pll_q_code == 4'h2;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_nop;
		w && reg_addr == 7'h01 && !reg_wdata[7] |=> !soft_reset_busy;
	endproperty
	a_nop: assert property (p_nop) else $error("nop");
	property p_adc;
		w && reg_addr == 7'h02 && reg_wdata < 8'hb0 |=> adc_rate_code == $past(reg_wdata[7:4]);
	endproperty
	a_adc: assert property (p_adc) else $error("adc");
	property p_dac;
		w && reg_addr == 7'h02 && reg_wdata[3:0] < 4'hb |=> dac_rate_code == $past(reg_wdata[3:0]);
	endproperty
	a_dac: assert property (p_dac) else $error("dac");
	property p_pll;
		w && reg_addr == 7'h03 |=> pll_enable == $past(reg_wdata[7]);
	endproperty
	a_pll: assert property (p_pll) else $error("pll");
	property p_rd;
		clk_en && reg_rd && !soft_reset_busy && reg_addr == 7'h00
			|=> reg_rdata == {7'h00, $past(active_page)};
	endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_ref;
		clk_en && pll_enable && pll_rate_tick && !soft_reset_busy |=> reference_sample_rate;
	endproperty
	a_ref: assert property (p_ref) else $error("ref");
endmodule
bind ccr_top ccr_chk ccr_chk_i (.*);

/* File: test/ccr_host.sv */
module ccr_host (
	input wire logic core_clk,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [6:0] reg_addr = 7'h00,
	output logic [7:0] reg_wdata = 8'h00,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule

/* File: test/codec_control_register_front_tb_top.sv */
module codec_control_register_front_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic divider_input_clock = 1'b0;
	logic pll_rate_tick = 1'b0;
	logic reg_wr;
	logic reg_rd;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic active_page;
	logic pll_enable;
	logic [3:0] pll_q_code;
	logic [3:0] adc_rate_code;
	logic [3:0] dac_rate_code;
	logic soft_reset_busy;
	logic reference_sample_rate;
	logic adc_sample_tick;
	logic dac_sample_tick;
	logic [7:0] rv;
	int failures = 0;
	int checks_done = 0;
	int na;
	int nd;
	logic [22:0] rows [8] = '{{7'h00, 8'h01, 8'h01}, {7'h02, 8'h33, 8'h00},
		{7'h00, 8'h00, 8'h00}, {7'h02, 8'h33, 8'h33}, {7'h02, 8'haa, 8'haa},
		{7'h03, 8'h90, 8'h90}, {7'h01, 8'h00, 8'h00}, {7'h7f, 8'h55, 8'h00}};
	always #10 core_clk = ~core_clk;
	ccr_top ccr_top_i (.*);
	ccr_host ccr_host_i (.*);
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		#1 chk({pll_enable, pll_q_code, active_page, soft_reset_busy, 1'b0}, 8'h10);
		chk({adc_rate_code, dac_rate_code}, 8'h00);
		chk(reg_rdata, 8'h00);
		foreach (rows[i])
		begin
			ccr_host_i.wr(rows[i][22:16], rows[i][15:8]);
			ccr_host_i.rd(rows[i][22:16], rv);
			chk(rv, rows[i][7:0]);
		end
		@(posedge core_clk) clk_en <= 1'b0;
		ccr_host_i.wr(7'h00, 8'h01);
		#1 chk({7'h00, active_page}, 8'h00);
		@(posedge core_clk) clk_en <= 1'b1;
		ccr_host_i.rd(7'h02, rv);
		chk(rv, 8'haa);
		ccr_host_i.wr(7'h01, 8'h80);
		#1 chk({7'h00, soft_reset_busy}, 8'h01);
		@(posedge core_clk);
		#1 chk({pll_enable, pll_q_code, active_page, soft_reset_busy, 1'b0}, 8'h10);
		chk({adc_rate_code, dac_rate_code}, 8'h00);
		ccr_host_i.rd(7'h03, rv);
		chk(rv, 8'h10);
		ccr_host_i.wr(7'h02, 8'h11);
		#1 chk({adc_rate_code, dac_rate_code}, 8'h11);
		ccr_host_i.wr(7'h03, 8'h90);
		na = 0;
		nd = 0;
		repeat (6)
		begin
			@(posedge core_clk) pll_rate_tick <= 1'b1;
			repeat (4)
			begin
				@(posedge core_clk) pll_rate_tick <= 1'b0;
				#1 na += adc_sample_tick;
				nd += dac_sample_tick;
			end
		end
		chk(8'(na), 8'h04);
		chk(8'(nd), 8'h04);
		ccr_host_i.wr(7'h03, 8'h10);
		nd = 0;
		for (int k = 0; k < 2400; k++)
		begin
			@(posedge core_clk) divider_input_clock <= k[1];
			#1 nd += reference_sample_rate;
		end
		chk(8'(nd), 8'h02);
		ccr_host_i.wr(7'h02, 8'h55);
		@(posedge core_clk) reset_n <= 1'b0;
		@(posedge core_clk) reset_n <= 1'b1;
		#1 chk({pll_enable, pll_q_code, active_page, soft_reset_busy, 1'b0}, 8'h10);
		chk({adc_rate_code, dac_rate_code}, 8'h00);
		chk(reg_rdata, 8'h00);
		results();
	end
endmodule
